/* File: tch_channel.sv */
// How it works
// R1: waveform mode: register-B compare acts on second line: none, set, clear, toggle.
// R2: waveform mode: register-C compare acts on second line by its two-bit code.
// R3: waveform mode: selected external event acts on second line by its code.
// R4: waveform mode: software trigger acts on second line by its code.
// R5: gray enable drives both lines from a 2-bit gray up/down counter.
// R6: writes to stepper, A, B, C are ignored while write lock is set.
// R7: counter value read returns live 16-bit count, upper bits zero.
// R8: registers A and B read-only in capture, read-write in waveform mode.
// R9: register C read-write in both modes, 16-bit compare value.
// R10: overflow flag, bit 0, set on counter overflow, cleared by status read.
// R11: capture only: load overrun flag, bit 1, cleared by status read.
// R12: waveform only: A and B compare flags, bits 2 and 3, clear on read.
// R13: register-C compare flag, bit 4, any mode, clear on status read.
// R14: capture only: A and B load flags, bits 5 and 6, clear on read.
// R15: external trigger flag, bit 7, cleared by status read.
// R16: status bit 16 shows whether the counter clock is enabled.
// R17: status bits 17, 18 mirror both lines: pin level in capture mode, waveform state in waveform mode.
// R18: writing ones to interrupt enable sets matching mask bits.
// R19: writing ones to interrupt disable clears matching mask bits.
// R20: mask register reads which of eight interrupts are enabled.
// R21: interrupt output high while any enabled status flag is set.
//
// Local design decision: the APB slave port.
`default_nettype none
module tch_channel (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        io_line_first_i,
  output logic             io_line_first_o,
  output logic             io_line_first_oe_n,
  input  wire logic        io_line_second_i,
  output logic             io_line_second_o,
  output logic             io_line_second_oe_n,
  input  wire logic        ext_event_i,
  output logic             irq
);
  // synchronisers: stage 1 feeds only stage 2
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] sync3_q;
  logic       la_s;
  logic       lb_s;
  logic       ev_s;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      sync3_q <= 3'h0;
    end else if (clk_en) begin
      sync1_q <= {ext_event_i, io_line_second_i, io_line_first_i};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end
  assign la_s = sync2_q[0];
  assign lb_s = sync2_q[1];
  assign ev_s = sync2_q[2];

  // apb: one wait state, the access completes when pready is high
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;
  logic        acc;
  logic        wr;
  logic        rd;
  logic        mapped;

  assign acc = psel & penable & pready_q;
  assign wr  = acc & pwrite;
  assign rd  = acc & ~pwrite;

  tch_pkg::tch_mode_t mode_q;
  logic        gray_en_q;
  logic        down_q;
  logic        lock_q;
  logic [15:0] count_q;
  logic [15:0] ra_q;
  logic [15:0] rb_q;
  logic [15:0] rc_q;
  logic [7:0]  flags_q;
  logic [7:0]  mask_q;
  logic        clk_on_q;
  logic        la_q;
  logic        lb_q;
  logic [1:0]  gbin_q;
  logic        unread_a_q;
  logic        unread_b_q;
  logic        load_sel_q;
  logic        irq_q;
  logic        lo_q;
  logic        lo_oe_n_q;
  logic        lbo_q;
  logic        lbo_oe_n_q;

  always_comb begin
    unique case (paddr)
      tch_pkg::CTRL_ADDR, tch_pkg::MODE_ADDR, tch_pkg::STEPPER_ADDR,
      tch_pkg::COUNT_ADDR, tch_pkg::REG_FIRST_ADDR, tch_pkg::REG_SECOND_ADDR,
      tch_pkg::REG_THIRD_ADDR, tch_pkg::STATUS_ADDR, tch_pkg::IRQ_EN_ADDR,
      tch_pkg::IRQ_DIS_ADDR, tch_pkg::IRQ_MASK_ADDR, tch_pkg::LOCK_ADDR:
        mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // events
  logic wave;
  logic tick;
  logic ovf_ev;
  logic cpa_ev;
  logic cpb_ev;
  logic cpc_ev;
  logic ext_edge;
  logic ext_ev;
  logic swtrg;
  logic restart;
  logic la_rise;
  logic lda_ev;
  logic ldb_ev;
  logic ovr_ev;
  logic st_rd;

  assign wave     = mode_q.wave;
  assign tick     = clk_on_q;
  assign ovf_ev   = tick & (count_q == tch_pkg::COUNT_MAX);
  assign cpa_ev   = tick & wave & (count_q == ra_q);
  assign cpb_ev   = tick & wave & (count_q == rb_q);
  assign cpc_ev   = tick & (count_q == rc_q);
  assign ext_edge = (mode_q.ext_edge[0] & ev_s & ~sync3_q[2]) |
                    (mode_q.ext_edge[1] & ~ev_s & sync3_q[2]);
  assign ext_ev   = ext_edge;
  assign swtrg    = wr & (paddr == tch_pkg::CTRL_ADDR) & pwdata[tch_pkg::CTRL_SWTRG_BIT];
  assign restart  = swtrg | (ext_ev & mode_q.etrg_en) | (cpc_ev & mode_q.rc_trig);
  assign la_rise  = la_s & ~sync3_q[0];
  assign lda_ev   = ~wave & la_rise & ~load_sel_q;
  assign ldb_ev   = ~wave & la_rise & load_sel_q;
  assign ovr_ev   = (lda_ev & unread_a_q) | (ldb_ev & unread_b_q);
  assign st_rd    = rd & (paddr == tch_pkg::STATUS_ADDR);

  function automatic logic apply_act(input tch_pkg::tch_act_t a, input logic cur);
    unique case (a)
      tch_pkg::TCH_ACT_NONE:   apply_act = cur;
      tch_pkg::TCH_ACT_SET:    apply_act = 1'b1;
      tch_pkg::TCH_ACT_CLEAR:  apply_act = 1'b0;
      tch_pkg::TCH_ACT_TOGGLE: apply_act = ~cur;
    endcase
  endfunction

  // later actions take priority: sw trigger over ext event over compares
  logic lb_d;
  always_comb begin
    lb_d = lb_q;
    if (cpb_ev) begin
      lb_d = apply_act(mode_q.cpb_act, lb_d); // R1
    end
    if (cpc_ev & wave) begin
      lb_d = apply_act(mode_q.cpc_act, lb_d); // R2
    end
    if (ext_ev & wave) begin
      lb_d = apply_act(mode_q.eevt_act, lb_d); // R3
    end
    if (swtrg & wave) begin
      lb_d = apply_act(mode_q.swtrg_act, lb_d); // R4
    end
  end

  // apb handshake and read data
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else if (clk_en) begin
      pready_q  <= psel & penable & ~pready_q;
      pslverr_q <= psel & penable & ~pready_q & ~mapped;
      if (psel & penable & ~pready_q & ~pwrite) begin
        prdata_q <= 32'h0000_0000;
        unique case (paddr)
          tch_pkg::MODE_ADDR: begin
            prdata_q[31:24] <= {mode_q.swtrg_act, mode_q.eevt_act,
                                mode_q.cpc_act, mode_q.cpb_act};
            prdata_q[tch_pkg::MODE_WAVE_BIT]    <= mode_q.wave;
            prdata_q[tch_pkg::MODE_RC_TRG_BIT]  <= mode_q.rc_trig;
            prdata_q[tch_pkg::MODE_ETRG_EN_BIT] <= mode_q.etrg_en;
            prdata_q[tch_pkg::MODE_EDGE_LSB +: 2] <= mode_q.ext_edge;
          end
          tch_pkg::STEPPER_ADDR: begin
            prdata_q[tch_pkg::STEP_GRAY_BIT] <= gray_en_q;
            prdata_q[tch_pkg::STEP_DOWN_BIT] <= down_q;
          end
          tch_pkg::COUNT_ADDR:      prdata_q[15:0] <= count_q; // R7
          tch_pkg::REG_FIRST_ADDR:  prdata_q[15:0] <= ra_q;
          tch_pkg::REG_SECOND_ADDR: prdata_q[15:0] <= rb_q;
          tch_pkg::REG_THIRD_ADDR:  prdata_q[15:0] <= rc_q; // R9
          tch_pkg::STATUS_ADDR: begin
            prdata_q[7:0]            <= flags_q;
            prdata_q[tch_pkg::ST_CLK] <= clk_on_q; // R16
            prdata_q[tch_pkg::ST_MA]  <= wave ? la_q : la_s; // R17
            prdata_q[tch_pkg::ST_MB]  <= wave ? lb_q : lb_s; // R17
          end
          tch_pkg::IRQ_MASK_ADDR: prdata_q[7:0] <= mask_q; // R20
          tch_pkg::LOCK_ADDR:     prdata_q[tch_pkg::LOCK_BIT] <= lock_q;
          default:                prdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // configuration registers
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      mode_q    <= '0;
      gray_en_q <= 1'b0;
      down_q    <= 1'b0;
      lock_q    <= 1'b0;
      rc_q      <= tch_pkg::COUNT_RESET;
    end else if (clk_en && wr) begin
      if (paddr == tch_pkg::LOCK_ADDR) begin
        lock_q <= pwdata[tch_pkg::LOCK_BIT];
      end
      if (!lock_q) begin // R6
        unique case (paddr)
          tch_pkg::MODE_ADDR: begin
            mode_q.swtrg_act <= tch_pkg::tch_act_t'(pwdata[tch_pkg::MODE_SWTRG_LSB +: 2]);
            mode_q.eevt_act  <= tch_pkg::tch_act_t'(pwdata[tch_pkg::MODE_EEVT_LSB +: 2]);
            mode_q.cpc_act   <= tch_pkg::tch_act_t'(pwdata[tch_pkg::MODE_CPC_LSB +: 2]);
            mode_q.cpb_act   <= tch_pkg::tch_act_t'(pwdata[tch_pkg::MODE_CPB_LSB +: 2]);
            mode_q.wave      <= pwdata[tch_pkg::MODE_WAVE_BIT];
            mode_q.rc_trig   <= pwdata[tch_pkg::MODE_RC_TRG_BIT];
            mode_q.etrg_en   <= pwdata[tch_pkg::MODE_ETRG_EN_BIT];
            mode_q.ext_edge  <= pwdata[tch_pkg::MODE_EDGE_LSB +: 2];
          end
          tch_pkg::STEPPER_ADDR: begin
            gray_en_q <= pwdata[tch_pkg::STEP_GRAY_BIT];
            down_q    <= pwdata[tch_pkg::STEP_DOWN_BIT];
          end
          tch_pkg::REG_THIRD_ADDR: rc_q <= pwdata[15:0]; // R9
          default: ;
        endcase
      end
    end
  end

  // registers A and B: captured in capture mode, written in waveform mode
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ra_q       <= tch_pkg::COUNT_RESET;
      rb_q       <= tch_pkg::COUNT_RESET;
      unread_a_q <= 1'b0;
      unread_b_q <= 1'b0;
      load_sel_q <= 1'b0;
    end else if (clk_en) begin
      if (lda_ev) begin
        ra_q <= count_q;
      end else if (wr && wave && !lock_q && paddr == tch_pkg::REG_FIRST_ADDR) begin
        ra_q <= pwdata[15:0]; // R8
      end
      if (ldb_ev) begin
        rb_q <= count_q;
      end else if (wr && wave && !lock_q && paddr == tch_pkg::REG_SECOND_ADDR) begin
        rb_q <= pwdata[15:0]; // R8
      end
      // a load in the same cycle as a read leaves the new value unread
      if (lda_ev) begin
        unread_a_q <= 1'b1;
      end else if (rd && paddr == tch_pkg::REG_FIRST_ADDR) begin
        unread_a_q <= 1'b0;
      end
      if (ldb_ev) begin
        unread_b_q <= 1'b1;
      end else if (rd && paddr == tch_pkg::REG_SECOND_ADDR) begin
        unread_b_q <= 1'b0;
      end
      if (restart || wave) begin
        load_sel_q <= 1'b0;
      end else if (la_rise) begin
        load_sel_q <= ~load_sel_q;
      end
    end
  end

  // counter and its clock gate
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      count_q  <= tch_pkg::COUNT_RESET;
      clk_on_q <= 1'b0;
    end else if (clk_en) begin
      if (restart) begin
        count_q <= tch_pkg::COUNT_RESET;
      end else if (tick) begin
        count_q <= count_q + 16'h0001;
      end
      if (wr && paddr == tch_pkg::CTRL_ADDR && pwdata[tch_pkg::CTRL_CLK_DIS_BIT]) begin
        clk_on_q <= 1'b0;
      end else if (restart ||
                   (wr && paddr == tch_pkg::CTRL_ADDR && pwdata[tch_pkg::CTRL_CLK_EN_BIT])) begin
        clk_on_q <= 1'b1;
      end
    end
  end

  // sticky flags: a read clears only what it reported, so a late event survives it
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  always_comb begin
    flag_set             = 8'h00;
    flag_set[tch_pkg::ST_OVF] = ovf_ev; // R10
    flag_set[tch_pkg::ST_OVR] = ovr_ev; // R11
    flag_set[tch_pkg::ST_CPA] = cpa_ev; // R12
    flag_set[tch_pkg::ST_CPB] = cpb_ev; // R12
    flag_set[tch_pkg::ST_CPC] = cpc_ev; // R13
    flag_set[tch_pkg::ST_LDA] = lda_ev; // R14
    flag_set[tch_pkg::ST_LDB] = ldb_ev; // R14
    flag_set[tch_pkg::ST_ETR] = ext_ev; // R15
    flag_clr = (st_rd ? prdata_q[7:0] : 8'h00) |
               (wave ? tch_pkg::CAPTURE_ONLY : tch_pkg::WAVE_ONLY);
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      flags_q <= tch_pkg::FLAGS_RESET;
      mask_q  <= tch_pkg::FLAGS_RESET;
      irq_q   <= 1'b0;
    end else if (clk_en) begin
      flags_q <= (flags_q & ~flag_clr) | flag_set; // R10
      if (wr && paddr == tch_pkg::IRQ_EN_ADDR) begin
        mask_q <= mask_q | pwdata[7:0]; // R18
      end else if (wr && paddr == tch_pkg::IRQ_DIS_ADDR) begin
        mask_q <= mask_q & ~pwdata[7:0]; // R19
      end
      irq_q <= |(flags_q & mask_q); // R21
    end
  end

  // line drive: waveform state, gray stepper, or input in capture mode
  logic [1:0] gbin_d;
  always_comb begin
    gbin_d = gbin_q;
    if (tick) begin
      gbin_d = down_q ? gbin_q - 2'b01 : gbin_q + 2'b01; // R5
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      la_q       <= 1'b0;
      lb_q       <= 1'b0;
      gbin_q     <= 2'b00;
      lo_q       <= 1'b0;
      lo_oe_n_q  <= 1'b1;
      lbo_q      <= 1'b0;
      lbo_oe_n_q <= 1'b1;
    end else if (clk_en) begin
      gbin_q <= gbin_d;
      if (wave) begin
        lb_q <= lb_d;
        if (cpa_ev) begin
          la_q <= ~la_q;
        end
      end
      // gray code of the step count: bit1 = b1, bit0 = b1 ^ b0
      if (gray_en_q) begin
        lo_q       <= gbin_q[1] ^ gbin_q[0]; // R5
        lbo_q      <= gbin_q[1]; // R5
        lo_oe_n_q  <= 1'b0;
        lbo_oe_n_q <= 1'b0;
      end else begin
        lo_q       <= la_q;
        lbo_q      <= lb_q;
        lo_oe_n_q  <= ~wave;
        lbo_oe_n_q <= ~wave;
      end
    end
  end

  assign prdata              = prdata_q;
  assign pready              = pready_q;
  assign pslverr             = pslverr_q;
  assign io_line_first_o     = lo_q;
  assign io_line_first_oe_n  = lo_oe_n_q;
  assign io_line_second_o    = lbo_q;
  assign io_line_second_oe_n = lbo_oe_n_q;
  assign irq                 = irq_q;
endmodule
`default_nettype wire

/* File: tch_monitor.sv */
`default_nettype none
module tch_monitor (
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        io_line_first_i,
  input wire logic        io_line_first_o,
  input wire logic        io_line_first_oe_n,
  input wire logic        io_line_second_i,
  input wire logic        io_line_second_o,
  input wire logic        io_line_second_oe_n,
  input wire logic        ext_event_i,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  logic rd_q;
  assign rd_q = pready && !pwrite;
  AST_RDY_PULSE: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  AST_RDY_WAIT: assert property ($rose(penable) && psel |=> pready)
    else $error("ready not one cycle after access start");
  AST_RDY_QUAL: assert property (pready |-> psel && penable)
    else $error("ready outside an access");
  AST_ERR_RDY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_UNMAPPED: assert property (pready && paddr == 32'h4001000c |-> pslverr)
    else $error("hole address not refused");
  AST_COUNT_HI: assert property (
    rd_q && paddr == tch_pkg::COUNT_ADDR |-> prdata[31:16] == 16'h0000)
    else $error("count upper bits not zero");
  AST_STATUS_GAPS: assert property (
    rd_q && paddr == tch_pkg::STATUS_ADDR |-> prdata[31:19] == 13'h0 && prdata[15:8] == 8'h0)
    else $error("status reserved bits set");
  AST_WO_READ: assert property (
    rd_q && paddr == tch_pkg::IRQ_EN_ADDR |-> prdata == 32'h0)
    else $error("write-only register reads nonzero");
  AST_MIRROR_B: assert property (
    rd_q && paddr == tch_pkg::STATUS_ADDR && !io_line_second_oe_n
      && $stable(io_line_second_o) |-> prdata[18] == io_line_second_o)
    else $error("second line mirror differs from driven level");
  AST_IRQ_MASK: assert property (
    rd_q && paddr == tch_pkg::IRQ_MASK_ADDR && prdata[7:0] == 8'h0 |-> !irq)
    else $error("interrupt with empty mask");
endmodule
bind tch_channel tch_monitor u_mon (.clk_sys, .reset_n, .clk_en, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .io_line_first_i, .io_line_first_o,
  .io_line_first_oe_n, .io_line_second_i, .io_line_second_o, .io_line_second_oe_n,
  .ext_event_i, .irq);
`default_nettype wire

/* File: tch_pin_model.sv */
`default_nettype none
// outside world on the two timer lines: drives its level only while the channel listens
module tch_pin_model (
  input  wire logic fo,
  input  wire logic foe_n,
  input  wire logic so,
  input  wire logic soe_n,
  input  wire logic fext,
  input  wire logic sext,
  output logic      fpin,
  output logic      spin
);
  timeunit 1ns;
  timeprecision 1ns;
  assign fpin = foe_n ? fext : fo;
  assign spin = soe_n ? sext : so;
endmodule
`default_nettype wire

/* File: tch_pkg.sv */
`default_nettype none
package tch_pkg;
  localparam logic [31:0] BASE_ADDR       = 32'h4001_0000;
  localparam logic [31:0] CTRL_ADDR       = 32'h4001_0000;
  localparam logic [31:0] MODE_ADDR       = 32'h4001_0004;
  localparam logic [31:0] STEPPER_ADDR    = 32'h4001_0008;
  localparam logic [31:0] COUNT_ADDR      = 32'h4001_0010;
  localparam logic [31:0] REG_FIRST_ADDR  = 32'h4001_0014;
  localparam logic [31:0] REG_SECOND_ADDR = 32'h4001_0018;
  localparam logic [31:0] REG_THIRD_ADDR  = 32'h4001_001c;
  localparam logic [31:0] STATUS_ADDR     = 32'h4001_0020;
  localparam logic [31:0] IRQ_EN_ADDR     = 32'h4001_0024;
  localparam logic [31:0] IRQ_DIS_ADDR    = 32'h4001_0028;
  localparam logic [31:0] IRQ_MASK_ADDR   = 32'h4001_002c;
  localparam logic [31:0] LOCK_ADDR       = 32'h4001_0030;
  // control register bits
  localparam int CTRL_CLK_EN_BIT  = 0;
  localparam int CTRL_CLK_DIS_BIT = 1;
  localparam int CTRL_SWTRG_BIT   = 2;
  // mode register field positions
  localparam int MODE_EDGE_LSB    = 8;
  localparam int MODE_ETRG_EN_BIT = 12;
  localparam int MODE_RC_TRG_BIT  = 14;
  localparam int MODE_WAVE_BIT    = 15;
  localparam int MODE_CPB_LSB     = 24;
  localparam int MODE_CPC_LSB     = 26;
  localparam int MODE_EEVT_LSB    = 28;
  localparam int MODE_SWTRG_LSB   = 30;
  // stepper and lock register bits
  localparam int STEP_GRAY_BIT    = 0;
  localparam int STEP_DOWN_BIT    = 1;
  localparam int LOCK_BIT         = 0;
  // status bit positions
  localparam int ST_OVF = 0;
  localparam int ST_OVR = 1;
  localparam int ST_CPA = 2;
  localparam int ST_CPB = 3;
  localparam int ST_CPC = 4;
  localparam int ST_LDA = 5;
  localparam int ST_LDB = 6;
  localparam int ST_ETR = 7;
  localparam int ST_CLK = 16;
  localparam int ST_MA  = 17;
  localparam int ST_MB  = 18;
  localparam logic [7:0]  FLAGS_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX   = 16'hffff;
  // flags forced low in each mode
  localparam logic [7:0]  CAPTURE_ONLY = 8'h62;
  localparam logic [7:0]  WAVE_ONLY    = 8'h0c;

  typedef enum logic [1:0] {
    TCH_ACT_NONE   = 2'b00,
    TCH_ACT_SET    = 2'b01,
    TCH_ACT_CLEAR  = 2'b10,
    TCH_ACT_TOGGLE = 2'b11
  } tch_act_t;

  typedef struct packed {
    tch_act_t   swtrg_act;
    tch_act_t   eevt_act;
    tch_act_t   cpc_act;
    tch_act_t   cpb_act;
    logic       wave;
    logic       rc_trig;
    logic       etrg_en;
    logic [1:0] ext_edge;
  } tch_mode_t;
endpackage
`default_nettype wire

/* File: tch_tb.sv */
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] A_ST = tch_pkg::STATUS_ADDR;
  localparam logic [31:0] A_MD = tch_pkg::MODE_ADDR;
  localparam logic [31:0] A_CT = tch_pkg::CTRL_ADDR;
  logic        clk_sys, reset_n, psel, penable, pwrite, ev, lv_a, lv_b, er, ce;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic        pready, pslverr, a_o, a_oe_n, b_o, b_oe_n, a_p, b_p, irq;
  logic [1:0]  s;
  int          miscompares, check_count;
  tch_channel uut (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .io_line_first_i(a_p), .io_line_first_o(a_o),
    .io_line_first_oe_n(a_oe_n), .io_line_second_i(b_p), .io_line_second_o(b_o),
    .io_line_second_oe_n(b_oe_n), .ext_event_i(ev), .irq(irq));
  tch_pin_model u_pins (.fo(a_o), .foe_n(a_oe_n), .so(b_o), .soe_n(b_oe_n),
    .fext(lv_a), .sext(lv_b), .fpin(a_p), .spin(b_p));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // held steady until ready is sampled; one idle cycle keeps drives apart
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  function automatic logic [31:0] md(input logic [7:0] f);
    return {f, 24'h008000};
  endfunction
  task automatic wait_cnt(input logic [15:0] n);
    do apb(1'b0, tch_pkg::COUNT_ADDR, 32'h0); while (rd[15:0] < n);
  endtask
  task automatic t_regs;
    apb(1'b1, tch_pkg::REG_THIRD_ADDR, 32'h1234);
    apb(1'b0, tch_pkg::REG_THIRD_ADDR, 32'h0);
    chk("third", 32'h1234, rd);
    apb(1'b1, tch_pkg::REG_FIRST_ADDR, 32'h55);
    apb(1'b0, tch_pkg::REG_FIRST_ADDR, 32'h0);
    chk("first capture", 32'h0, rd);
    apb(1'b1, tch_pkg::LOCK_ADDR, 32'h1);
    apb(1'b1, tch_pkg::REG_THIRD_ADDR, 32'h99);
    apb(1'b1, tch_pkg::STEPPER_ADDR, 32'h1);
    apb(1'b0, tch_pkg::REG_THIRD_ADDR, 32'h0);
    chk("third locked", 32'h1234, rd);
    apb(1'b0, tch_pkg::STEPPER_ADDR, 32'h0);
    chk("stepper locked", 32'h0, rd);
    apb(1'b1, tch_pkg::LOCK_ADDR, 32'h0);
    apb(1'b1, A_MD, md(8'h00));
    apb(1'b1, tch_pkg::REG_FIRST_ADDR, 32'h55);
    apb(1'b0, tch_pkg::REG_FIRST_ADDR, 32'h0);
    chk("first wave", 32'h55, rd);
    apb(1'b0, 32'h4001000c, 32'h0);
    chk("hole err", 32'h1, er);
    apb(1'b0, tch_pkg::IRQ_EN_ADDR, 32'h0);
    chk("enable reads zero", 32'h0, rd);
  endtask
  task automatic t_sw;
    logic [1:0] c [5] = '{2'd1, 2'd2, 2'd3, 2'd0, 2'd3};
    logic       e [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, A_MD, md({c[i], 6'h0}));
      apb(1'b1, A_CT, 32'h4);
      repeat (3) @(posedge clk_sys);
      chk("second line", e[i], b_o);
      apb(1'b0, A_ST, 32'h0);
      chk("second mirror", e[i], rd[18]);
      chk("clock on", 32'h1, rd[16]);
    end
    chk("second driven", 32'h0, b_oe_n);
    apb(1'b1, A_CT, 32'h2);
    apb(1'b0, A_ST, 32'h0);
    chk("clock off", 32'h0, rd[16]);
    apb(1'b1, A_CT, 32'h1);
    apb(1'b0, A_ST, 32'h0);
    chk("clock on again", 32'h1, rd[16]);
    apb(1'b1, A_CT, 32'h2);
  endtask
  task automatic t_cmp;
    logic [31:0] c0;
    apb(1'b1, tch_pkg::REG_SECOND_ADDR, 32'd20);
    apb(1'b1, tch_pkg::REG_THIRD_ADDR, 32'd40);
    apb(1'b1, A_MD, md(8'b10_00_10_01));
    apb(1'b1, A_CT, 32'h4);
    apb(1'b0, A_ST, 32'h0);
    wait_cnt(16'd28);
    chk("b compare set", 32'h1, b_o);
    apb(1'b0, A_ST, 32'h0);
    chk("b compare flag", 32'h1, rd[3]);
    chk("c flag early", 32'h0, rd[4]);
    wait_cnt(16'd48);
    chk("c compare clear", 32'h0, b_o);
    apb(1'b0, A_ST, 32'h0);
    chk("c compare flag", 32'h1, rd[4]);
    chk("b flag cleared", 32'h0, rd[3]);
    chk("load flags wave", 32'h0, rd[6:5]);
    // five frozen edges between two reads nine edges apart leave four counts
    apb(1'b0, tch_pkg::COUNT_ADDR, 32'h0);
    c0 = rd;
    ce <= 1'b0;
    repeat (5) @(posedge clk_sys);
    ce <= 1'b1;
    apb(1'b0, tch_pkg::COUNT_ADDR, 32'h0);
    chk("frozen count", c0 + 32'd4, rd);
  endtask
  task automatic t_evt;
    apb(1'b1, A_MD, md(8'b00_11_00_00) | 32'h1300);
    apb(1'b0, A_ST, 32'h0);
    ev <= 1'b1;
    repeat (8) @(posedge clk_sys);
    chk("event toggle", 32'h1, b_o);
    apb(1'b0, A_ST, 32'h0);
    chk("trigger flag", 32'h1, rd[7]);
    ev <= 1'b0;
    repeat (8) @(posedge clk_sys);
    chk("event fall toggle", 32'h0, b_o);
  endtask
  task automatic t_cap;
    apb(1'b1, A_MD, 32'h0);
    apb(1'b0, A_ST, 32'h0);
    for (int i = 0; i < 3; i++) begin
      lv_a <= 1'b1;
      repeat (5) @(posedge clk_sys);
      apb(1'b0, A_ST, 32'h0);
      chk("first mirror", 32'h1, rd[17]);
      chk("compare flags", 32'h0, rd[3:2]);
      if (i == 0) chk("load a", 32'h1, rd[6:5]);
      if (i == 1) chk("load b", 32'h2, rd[6:5]);
      if (i == 2) chk("overrun", 32'h1, rd[1]);
      lv_a <= 1'b0;
      repeat (5) @(posedge clk_sys);
    end
  endtask
  task automatic t_gray;
    for (int d = 0; d < 2; d++) begin
      apb(1'b1, tch_pkg::STEPPER_ADDR, d ? 32'h3 : 32'h1);
      @(posedge clk_sys);
      chk("gray drives", 32'h0, {a_oe_n, b_oe_n});
      s = {b_o, a_o};
      for (int k = 0; k < 4; k++) begin
        @(posedge clk_sys);
        chk("gray step", d ? {~s[0], s[1]} : {s[0], ~s[1]}, {b_o, a_o});
        s = {b_o, a_o};
      end
    end
    apb(1'b1, tch_pkg::STEPPER_ADDR, 32'h0);
  endtask
  task automatic t_ovf;
    apb(1'b1, tch_pkg::IRQ_EN_ADDR, 32'h1);
    apb(1'b0, tch_pkg::IRQ_MASK_ADDR, 32'h0);
    chk("mask on", 32'h1, rd);
    apb(1'b1, A_CT, 32'h4);
    apb(1'b0, A_ST, 32'h0);
    chk("irq idle", 32'h0, irq);
    // a full 16-bit wrap is the only way to reach overflow
    repeat (65545) @(posedge clk_sys);
    chk("irq raised", 32'h1, irq);
    apb(1'b0, A_ST, 32'h0);
    chk("overflow", 32'h1, rd[0]);
    @(posedge clk_sys);
    chk("irq cleared", 32'h0, irq);
    apb(1'b0, A_ST, 32'h0);
    chk("overflow read", 32'h0, rd[0]);
    apb(1'b1, tch_pkg::IRQ_DIS_ADDR, 32'h1);
    apb(1'b0, tch_pkg::IRQ_MASK_ADDR, 32'h0);
    chk("mask off", 32'h0, rd);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk_sys);
    miscompares++;
    give_verdict;
  end
  initial begin
    {reset_n, psel, penable, pwrite, ev, lv_a, lv_b} = 7'h0;
    ce = 1'b1;
    {paddr, pwdata} = 64'h0;
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    t_regs;
    t_sw;
    t_cmp;
    t_evt;
    t_cap;
    t_gray;
    t_ovf;
    give_verdict;
  end
endmodule
`default_nettype wire
